// >>> inc/pfm_erase_pkg.sv
// Contract
// R01 - Erase from the CPU works on one whole sector only, never words.
// R02 - Sector comes from address bits 21:8; bits 7:0 are ignored.
// R03 - Enable bit must be set; nothing is erased while it is clear.
// R04 - Trigger starts erase only with enable set and a fresh key pair.
// R05 - Key register takes CCh then 33h, right before the trigger.
// R06 - CPU is halted for the whole erase; the timer ends it.
// R07 - Software loads address, sets enable, writes keys, then trigger.
// R08 - Protected sector: trigger cleared, flash untouched, error flag set.
// R09 - Trigger with address outside the map sets error, no erase.
// R10 - On completion trigger clears, done flag sets, interrupt if enabled.
// R11 - Erase leaves holding registers and the enable bit unchanged.
// R12 - An erase cut short by an unexpected event sets the error flag.
// R13 - Software writes first key, second key, then trigger, in order.
// R14 - Broken timing between key writes and trigger cancels the operation.
// R15 - Done and error stay set until cleared; each erase needs new keys.
package pfm_erase_pkg;

   // ========================================
   // Bus and flash geometry
   localparam int ADDR_W       = 5;
   localparam int DATA_W       = 32;
   localparam int FLASH_ADDR_W = 22;
   localparam int SECTOR_LSB   = 8;
   localparam int SECTOR_W     = 14;
   localparam int FLASH_SECTORS_DEF = 128;

   // ========================================
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL0  = 5'h00;  // memory_control_zero
   localparam logic [4:0] OFS_CTRL1  = 5'h04;  // memory_control_one
   localparam logic [4:0] OFS_KEY    = 5'h08;  // unlock_key_register
   localparam logic [4:0] OFS_ADDR   = 5'h0c;  // flash_target_address
   localparam logic [4:0] OFS_STATUS = 5'h10;  // sticky events, W1C
   localparam logic [4:0] OFS_MASK   = 5'h14;  // interrupt mask
   localparam logic [4:0] OFS_PROT   = 5'h18;  // protected sector limit

   // ========================================
   // Field positions
   localparam int BIT_ENABLE  = 0;  // memory_control_zero
   localparam int BIT_TRIGGER = 0;  // memory_control_one
   localparam int BIT_ERROR   = 1;  // memory_control_one mirror
   localparam int BIT_DONE    = 2;  // memory_control_one mirror
   localparam int ST_DONE     = 0;  // status and mask
   localparam int ST_ERROR    = 1;  // status and mask

   // ========================================
   // Key pair and reset values
   localparam logic [7:0] KEY_FIRST  = 8'hcc;
   localparam logic [7:0] KEY_SECOND = 8'h33;
   localparam logic [SECTOR_W-1:0] RST_PROT = 14'h0000;
   localparam logic [1:0] RST_MASK = 2'h0;

   // ========================================
   // Timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int ERASE_TIME_NS  = 10000000;
   localparam int ERASE_CYCLES   = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int KEY_WINDOW_NS  = 40;
   localparam int KEY_WINDOW_CYC = KEY_WINDOW_NS / CLK_PERIOD_NS;

   // ========================================
   // Carriers
   typedef struct packed {
      logic                active;
      logic [SECTOR_W-1:0] sector;
   } erase_cmd_t;

   typedef struct packed {
      logic error;
      logic done;
   } status_t;

endpackage

// >>> rtl/pfm_prog_timer.sv
// ========================================
// Programming timer: fixed-length erase pulse
module pfm_prog_timer #(
   parameter int CYCLES = pfm_erase_pkg::ERASE_CYCLES
) (
   input  wire logic clk,     // System clock
   input  wire logic rst_n,   // Sync reset, active low
   input  wire logic start,   // Begin a timed cycle
   input  wire logic cancel,  // Drop the running cycle
   output logic      busy,    // Cycle running
   output logic      done     // One pulse at the end
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count;

   if (CYCLES < 2) begin : g_bad
      $error("pfm_prog_timer: CYCLES must be at least 2");
   end

   // Count down; done fires on the last tick
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (cancel) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (start && !busy) begin
         count <= CW'(CYCLES - 1);
         busy  <= 1'b1;
         done  <= 1'b0;
      end else if (busy && count == CW'(1)) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b1;
      end else begin
         count <= busy ? count - CW'(1) : count;
         done  <= 1'b0;
      end
   end

endmodule

// >>> rtl/pfm_sector_erase_sequencer.sv
// ========================================
// Sector erase sequencer, Avalon-MM slave
//
// The address map and the Avalon-MM slave port are this design's own decisions.
module pfm_sector_erase_sequencer #(
   parameter int ERASE_CYCLES  = pfm_erase_pkg::ERASE_CYCLES,
   parameter int KEY_WINDOW    = pfm_erase_pkg::KEY_WINDOW_CYC,
   parameter int FLASH_SECTORS = pfm_erase_pkg::FLASH_SECTORS_DEF
) (
   input  wire logic                     clk,              // 200 MHz
   input  wire logic                     rst_n,            // Sync reset
   input  wire logic [4:0]               avs_address,      // Byte address
   input  wire logic                     avs_read,         // Read request
   input  wire logic                     avs_write,        // Write request
   input  wire logic [31:0]              avs_writedata,    // Write data
   input  wire logic [3:0]               avs_byteenable,   // Byte lanes
   output logic [31:0]                   avs_readdata,     // Read data
   output logic                          avs_waitrequest,  // Stall
   input  wire logic                     abort_in,         // Async abort
   output logic                          irq,              // Level irq
   output logic                          cpu_halt,         // CPU stall
   output pfm_erase_pkg::erase_cmd_t     erase_cmd         // To array
);

   localparam int SW = pfm_erase_pkg::SECTOR_W;

   // ========================================
   // Elaboration checks
   if (ERASE_CYCLES < 2) begin : g_bad_erase
      $error("ERASE_CYCLES must be at least 2");
   end
   if (KEY_WINDOW < 1 || KEY_WINDOW > 14) begin : g_bad_window
      $error("KEY_WINDOW must lie in 1..14");
   end
   if (FLASH_SECTORS < 1 || FLASH_SECTORS > (1 << SW)) begin : g_bad_map
      $error("FLASH_SECTORS out of range");
   end

   localparam logic [SW:0] SECTOR_LIMIT = (SW + 1)'(FLASH_SECTORS);
   localparam logic [3:0]  WINDOW_LAST  = 4'(KEY_WINDOW);

   typedef enum logic [1:0] {K_IDLE, K_FIRST, K_ARMED} key_state_t;

   // ========================================
   // State
   logic                     mem_enable;
   logic                     trigger;
   logic [21:0]              flash_target_address;
   logic [SW-1:0]            prot_limit;
   logic [1:0]               irq_mask;
   pfm_erase_pkg::status_t   status;
   pfm_erase_pkg::status_t   next_status;
   key_state_t               key_state;
   logic [3:0]               key_gap;
   logic                     abort_meta;
   logic                     abort_s;
   logic                     timer_busy;
   logic                     timer_done;

   // ========================================
   // Decode
   logic          eval;
   logic          accept;
   logic          acc_wr;
   logic [31:0]   wmask;
   logic [SW-1:0] sector;
   logic          bad_addr;
   logic          protect_hit;
   logic          trig_wr;
   logic          start_erase;
   logic          reject;
   logic          end_ok;
   logic          end_abort;
   logic [31:0]   rd_mux;

   // Request seen once before answer; the erase holds the bus itself
   assign eval   = (avs_read | avs_write) & avs_waitrequest
                   & ~erase_cmd.active;
   assign accept = (avs_read | avs_write) & ~avs_waitrequest;
   assign acc_wr = accept & avs_write;
   assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Low address bits never reach the sector select
   assign sector = flash_target_address[21:8];  // [R02]
   assign bad_addr    = {1'b0, sector} >= SECTOR_LIMIT;
   assign protect_hit = sector < prot_limit;

   // Trigger write evaluated in the cycle before the answer
   assign trig_wr = eval & avs_write & (avs_address ==
                    pfm_erase_pkg::OFS_CTRL1) & avs_byteenable[0]
                    & avs_writedata[pfm_erase_pkg::BIT_TRIGGER];
   assign start_erase = trig_wr & ~bad_addr & ~protect_hit  // [R09]
                        & mem_enable                         // [R03]
                        & (key_state == K_ARMED);            // [R04]
   assign reject    = trig_wr & (bad_addr | protect_hit);    // [R08] [R09]
   assign end_ok    = erase_cmd.active & timer_done;         // [R06]
   assign end_abort = erase_cmd.active & abort_s & ~timer_done;

   // ========================================
   // Abort pin synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         abort_meta <= 1'b0;
         abort_s    <= 1'b0;
      end else begin
         abort_meta <= abort_in;
         abort_s    <= abort_meta;
      end
   end

   // ========================================
   // Programming timer
   pfm_prog_timer #(
      .CYCLES (ERASE_CYCLES)
   ) u_timer (
      .clk    (clk),
      .rst_n  (rst_n),
      .start  (start_erase),
      .cancel (end_abort),
      .busy   (timer_busy),
      .done   (timer_done)
   );

   // ========================================
   // Bus answer: one cycle for plain access, whole erase for a start
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if (eval && !start_erase) begin
         avs_waitrequest <= 1'b0;
      end else if (end_ok || end_abort) begin
         avs_waitrequest <= 1'b0;  // [R06]
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Read mux; write-only key reads as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         pfm_erase_pkg::OFS_CTRL0:  rd_mux = {31'h0, mem_enable};
         pfm_erase_pkg::OFS_CTRL1:  rd_mux = {29'h0, status.done,
                                             status.error, trigger};
         pfm_erase_pkg::OFS_ADDR:   rd_mux = {10'h0, flash_target_address};
         pfm_erase_pkg::OFS_STATUS: rd_mux = {30'h0, status};
         pfm_erase_pkg::OFS_MASK:   rd_mux = {30'h0, irq_mask};
         pfm_erase_pkg::OFS_PROT:   rd_mux = {18'h0, prot_limit};
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured so it stands at the answer edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (eval && avs_read) begin
         avs_readdata <= rd_mux;
      end
   end

   // ========================================
   // Enable bit; only software moves it, never the erase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_enable <= 1'b0;
      end else if (acc_wr && avs_address == pfm_erase_pkg::OFS_CTRL0 &&
                   avs_byteenable[0]) begin
         mem_enable <= avs_writedata[pfm_erase_pkg::BIT_ENABLE];  // [R11]
      end
   end

   // Target address, protection limit, mask
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_target_address <= 22'h000000;
         prot_limit           <= pfm_erase_pkg::RST_PROT;
         irq_mask             <= pfm_erase_pkg::RST_MASK;
      end else if (acc_wr) begin
         if (avs_address == pfm_erase_pkg::OFS_ADDR) begin
            flash_target_address <= (flash_target_address & ~wmask[21:0])
                                    | (avs_writedata[21:0] & wmask[21:0]);
         end
         if (avs_address == pfm_erase_pkg::OFS_PROT) begin
            prot_limit <= (prot_limit & ~wmask[SW-1:0])
                          | (avs_writedata[SW-1:0] & wmask[SW-1:0]);
         end
         if (avs_address == pfm_erase_pkg::OFS_MASK && avs_byteenable[0])
         begin
            irq_mask <= avs_writedata[1:0];
         end
      end
   end

   // ========================================
   // Trigger bit: set by a good start, cleared by hardware at the end;
   // software cannot clear it mid-erase because the bus is stalled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trigger <= 1'b0;
      end else if (start_erase) begin
         trigger <= 1'b1;
      end else if (end_ok || end_abort) begin
         trigger <= 1'b0;  // [R10]
      end
   end

   // Array command: one sector, frozen for the whole pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         erase_cmd <= '0;
         cpu_halt  <= 1'b0;
      end else if (start_erase) begin
         erase_cmd.active <= 1'b1;  // [R01]
         erase_cmd.sector <= sector;  // [R02]
         cpu_halt         <= 1'b1;  // [R06]
      end else if (end_ok || end_abort) begin
         erase_cmd.active <= 1'b0;
         cpu_halt         <= 1'b0;
      end
   end

   // ========================================
   // Key sequence: any other access between steps disarms
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         key_state <= K_IDLE;
         key_gap   <= 4'h0;
      end else if (accept) begin
         key_gap <= 4'h0;
         if (avs_write && avs_address == pfm_erase_pkg::OFS_KEY &&
             avs_byteenable[0]) begin
            if (avs_writedata[7:0] == pfm_erase_pkg::KEY_FIRST) begin
               key_state <= K_FIRST;  // [R05]
            end else if (avs_writedata[7:0] == pfm_erase_pkg::KEY_SECOND
                         && key_state == K_FIRST) begin
               key_state <= K_ARMED;  // [R05]
            end else begin
               key_state <= K_IDLE;
            end
         end else begin
            key_state <= K_IDLE;  // [R15]
         end
      end else if (key_state != K_IDLE && !erase_cmd.active) begin
         // Too long a pause means the sequence was interrupted
         if (key_gap == WINDOW_LAST) begin
            key_state <= K_IDLE;  // [R14]
            key_gap   <= 4'h0;
         end else begin
            key_gap <= key_gap + 4'h1;
         end
      end
   end

   // ========================================
   // Sticky status, write one to clear, a new event wins
   always_comb begin
      next_status = status;
      if (acc_wr && avs_address == pfm_erase_pkg::OFS_STATUS &&
          avs_byteenable[0]) begin
         next_status = status & ~avs_writedata[1:0];
      end
      if (end_ok) begin
         next_status.done = 1'b1;  // [R10]
      end
      if (reject || end_abort) begin
         next_status.error = 1'b1;  // [R12]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= '0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;  // [R15]
         irq    <= |(next_status & irq_mask);  // [R10]
      end
   end

   // ========================================
   // Checks
   AST_ENABLE_NEEDED: assert property (  // [R03]
      @(posedge clk) disable iff (!rst_n)
      $rose(erase_cmd.active) |-> $past(mem_enable))
      else $error("erase began with enable clear");

   AST_KEY_NEEDED: assert property (  // [R04]
      @(posedge clk) disable iff (!rst_n)
      $rose(erase_cmd.active) |-> $past(key_state) == K_ARMED)
      else $error("erase began without key pair");

   AST_KEY_ORDER: assert property (  // [R05]
      @(posedge clk) disable iff (!rst_n)
      $rose(key_state == K_ARMED) |-> $past(key_state) == K_FIRST)
      else $error("armed without first key");

   AST_SECTOR_SELECT: assert property (  // [R02]
      @(posedge clk) disable iff (!rst_n)
      $rose(erase_cmd.active) |->
         erase_cmd.sector == $past(flash_target_address[21:8]))
      else $error("wrong sector sent to array");

   AST_ONE_SECTOR: assert property (  // [R01]
      @(posedge clk) disable iff (!rst_n)
      erase_cmd.active && $past(erase_cmd.active) |->
         $stable(erase_cmd.sector))
      else $error("sector changed during erase");

   AST_HALT_HELD: assert property (  // [R06]
      @(posedge clk) disable iff (!rst_n)
      erase_cmd.active |-> cpu_halt && avs_waitrequest && trigger)
      else $error("CPU not stalled during erase");

   AST_PROTECT_REJECT: assert property (  // [R08]
      @(posedge clk) disable iff (!rst_n)
      trig_wr && protect_hit |=>
         status.error && !trigger && !erase_cmd.active)
      else $error("protected sector not rejected");

   AST_INVALID_REJECT: assert property (  // [R09]
      @(posedge clk) disable iff (!rst_n)
      trig_wr && bad_addr |=> status.error && !erase_cmd.active)
      else $error("invalid address not rejected");

   AST_DONE_REPORT: assert property (  // [R10]
      @(posedge clk) disable iff (!rst_n)
      end_ok |=> status.done && !trigger && !avs_waitrequest
                 ##1 (irq == irq_mask[pfm_erase_pkg::ST_DONE]))
      else $error("completion not reported");

   AST_ENABLE_KEPT: assert property (  // [R11]
      @(posedge clk) disable iff (!rst_n)
      end_ok |=> $stable(mem_enable))
      else $error("erase changed enable bit");

   AST_ABORT_ERROR: assert property (  // [R12]
      @(posedge clk) disable iff (!rst_n)
      end_abort |=> status.error && !erase_cmd.active && !status.done)
      else $error("cut erase not flagged");

   AST_KEY_TIMEOUT: assert property (  // [R14]
      @(posedge clk) disable iff (!rst_n)
      key_state != K_IDLE && !accept && !erase_cmd.active &&
      key_gap == WINDOW_LAST |=> key_state == K_IDLE)
      else $error("stale key not dropped");

   AST_KEY_SPENT: assert property (  // [R15]
      @(posedge clk) disable iff (!rst_n)
      end_ok |-> ##2 key_state == K_IDLE)
      else $error("key reused after erase");

   COV_ERASE_DONE: cover property (
      @(posedge clk) disable iff (!rst_n) end_ok);
   COV_PROTECT: cover property (
      @(posedge clk) disable iff (!rst_n) trig_wr && protect_hit);
   COV_ABORT: cover property (
      @(posedge clk) disable iff (!rst_n) end_abort);
   COV_IRQ: cover property (
      @(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule

// >>> bench/pfm_array_model.sv
// ========================================
// Flash array stand-in: watches erase pulses, can abort one
module pfm_array_model (
   input  wire logic                      clk,          // System clock
   input  wire logic                      rst_n,        // Sync reset
   input  wire pfm_erase_pkg::erase_cmd_t erase_cmd,    // Erase request
   input  wire logic                      cpu_halt,     // CPU stall
   input  wire logic                      abort_arm,    // Bench asks abort
   output logic                           abort_in,     // Unexpected event
   output int                             n_erase,      // Pulses seen
   output int                             act_len,      // Last pulse length
   output int                             halt_len,     // Last stall length
   output int                             n_glitch,     // Sector moved
   output logic [13:0]                    last_sector   // Sector erased
);
   timeunit 1ns;
   timeprecision 100ps;
   logic act_q;
   logic halt_q;

   // Abort while act_len is 4 or more; a pulse's first cycle still sees the previous pulse's length
   assign abort_in = abort_arm & (erase_cmd.active === 1'b1)
                     & (act_len >= 4);

   // One sector per pulse, address steady throughout
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         act_q       <= 1'b0;
         n_erase     <= 0;
         act_len     <= 0;
         n_glitch    <= 0;
         last_sector <= '0;
      end else begin
         act_q <= erase_cmd.active;
         if (erase_cmd.active && !act_q) begin
            n_erase     <= n_erase + 1;
            act_len     <= 1;
            last_sector <= erase_cmd.sector;
         end else if (erase_cmd.active) begin
            act_len <= act_len + 1;
            if (erase_cmd.sector !== last_sector)
               n_glitch <= n_glitch + 1;
         end
      end
   end

   // Stall length, compared with the pulse by the bench
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         halt_q   <= 1'b0;
         halt_len <= 0;
      end else begin
         halt_q <= cpu_halt;
         if (cpu_halt && !halt_q)
            halt_len <= 1;
         else if (cpu_halt)
            halt_len <= halt_len + 1;
      end
   end
endmodule

// >>> bench/pfm_sector_erase_sequencer_tb_top.sv
module pfm_sector_erase_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int ECYC = 20;  // Short erase keeps the run brief
   logic                      clk;
   logic                      rst_n;
   logic [4:0]                avs_address;
   logic                      avs_read;
   logic                      avs_write;
   logic [31:0]               avs_writedata;
   logic [31:0]               avs_readdata;
   logic                      avs_waitrequest;
   logic                      abort_in;
   logic                      abort_arm;
   logic                      irq;
   logic                      cpu_halt;
   pfm_erase_pkg::erase_cmd_t erase_cmd;
   int                        n_erase;
   int                        act_len;
   int                        halt_len;
   int                        n_glitch;
   logic [13:0]               last_sector;
   logic [31:0]               rd_data;
   int                        cyc_last;
   int                        errors;
   int                        n_checks;
   int                        ticks;
   int                        n0;

   pfm_sector_erase_sequencer #(
      .ERASE_CYCLES(ECYC)
   ) u_pfm_sector_erase_sequencer (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .abort_in(abort_in), .irq(irq), .cpu_halt(cpu_halt),
      .erase_cmd(erase_cmd));

   pfm_array_model u_pfm_array_model (
      .clk(clk), .rst_n(rst_n), .erase_cmd(erase_cmd),
      .cpu_halt(cpu_halt), .abort_arm(abort_arm), .abort_in(abort_in),
      .n_erase(n_erase), .act_len(act_len), .halt_len(halt_len),
      .n_glitch(n_glitch), .last_sector(last_sector));

   // ========================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      ticks++;
      if (ticks == 6000) begin
         errors++;
         $display("MISMATCH %0t run hung", $time);
         close_out();
      end
   end

   // ========================================
   // Checks and verdict
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         errors++;
         $display("MISMATCH %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ========================================
   // Avalon master: hold until waitrequest seen low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_address   <= a;
      avs_writedata <= d;
      cyc_last = 0;
      do begin
         @(posedge clk);
         cyc_last++;
      end while (avs_waitrequest !== 1'b0);  // Hang guard ends a lost answer
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_v(rd_data, exp);
   endtask
   // Gap < 0 puts a read between the key bytes
   task automatic erase_seq(input logic [21:0] adr, input logic en,
                            input logic [7:0] k1, input logic [7:0] k2,
                            input int gap);
      bus(1'b1, pfm_erase_pkg::OFS_ADDR, {10'h0, adr});
      bus(1'b1, pfm_erase_pkg::OFS_CTRL0, {31'h0, en});
      bus(1'b1, pfm_erase_pkg::OFS_KEY, {24'h0, k1});
      if (gap < 0)
         bus(1'b0, pfm_erase_pkg::OFS_MASK, 32'h0);
      repeat (gap > 0 ? gap : 0) @(posedge clk);
      bus(1'b1, pfm_erase_pkg::OFS_KEY, {24'h0, k2});
      bus(1'b1, pfm_erase_pkg::OFS_CTRL1, 32'h1);
   endtask

   // ========================================
   // Scenarios
   task automatic t_reset();
      rdchk(pfm_erase_pkg::OFS_CTRL0, 32'h0);
      rdchk(pfm_erase_pkg::OFS_STATUS, 32'h0);
      rdchk(pfm_erase_pkg::OFS_MASK, 32'h0);
      rdchk(pfm_erase_pkg::OFS_PROT, 32'h0);
      rdchk(5'h1c, 32'h0);
      chk_v(irq, 1'b0);
   endtask
   task automatic t_erase();
      bus(1'b1, pfm_erase_pkg::OFS_MASK, 32'h1);
      erase_seq(22'h0045ab, 1'b1, 8'hcc, 8'h33, 0);
      chk_n(n_erase, 1);
      chk_v(last_sector, 14'h0045);
      chk_n(n_glitch, 0);
      chk_n(act_len, ECYC);
      chk_n(halt_len, ECYC);
      chk_n(int'(cyc_last > ECYC), 1);
      chk_v(irq, 1'b1);
      rdchk(pfm_erase_pkg::OFS_CTRL1, 32'h4);
      rdchk(pfm_erase_pkg::OFS_CTRL0, 32'h1);
      rdchk(pfm_erase_pkg::OFS_ADDR, 32'h0045ab);
      bus(1'b1, pfm_erase_pkg::OFS_CTRL1, 32'h1);
      chk_n(n_erase, 1);
      rdchk(pfm_erase_pkg::OFS_STATUS, 32'h1);
      bus(1'b1, pfm_erase_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk_v(irq, 1'b0);
      rdchk(pfm_erase_pkg::OFS_STATUS, 32'h0);
   endtask
   // Enable off, wrong order, wrong byte, late byte, read between
   task automatic t_refused();
      logic [16:0] cases [5];
      cases = '{{1'b0, 16'hcc33}, {1'b1, 16'h33cc}, {1'b1, 16'hcc34},
                {1'b1, 16'hcc33}, {1'b1, 16'hcc33}};
      for (int i = 0; i < 5; i++) begin
         erase_seq(22'h0045ab, cases[i][16], cases[i][15:8],
                   cases[i][7:0], i == 3 ? 10 : (i == 4 ? -1 : 0));
         chk_n(n_erase, 1);
         rdchk(pfm_erase_pkg::OFS_STATUS, 32'h0);
      end
   endtask
   task automatic t_bad_addr();
      bus(1'b1, pfm_erase_pkg::OFS_MASK, 32'h3);
      bus(1'b1, pfm_erase_pkg::OFS_PROT, 32'h50);
      erase_seq(22'h0045ab, 1'b1, 8'hcc, 8'h33, 0);
      chk_n(n_erase, 1);
      rdchk(pfm_erase_pkg::OFS_CTRL1, 32'h2);
      chk_v(irq, 1'b1);
      bus(1'b1, pfm_erase_pkg::OFS_STATUS, 32'h2);
      bus(1'b1, pfm_erase_pkg::OFS_PROT, 32'h0);
      erase_seq(22'h008000, 1'b1, 8'hcc, 8'h33, 0);
      chk_n(n_erase, 1);
      rdchk(pfm_erase_pkg::OFS_STATUS, 32'h2);
      bus(1'b1, pfm_erase_pkg::OFS_STATUS, 32'h2);
   endtask
   task automatic t_abort();
      abort_arm <= 1'b1;
      erase_seq(22'h007fff, 1'b1, 8'hcc, 8'h33, 0);
      abort_arm <= 1'b0;
      repeat (6) @(posedge clk);
      chk_n(n_erase, 2);
      chk_v(last_sector, 14'h007f);
      chk_n(int'(act_len < ECYC), 1);
      rdchk(pfm_erase_pkg::OFS_STATUS, 32'h2);
   endtask

   // ========================================
   // Main sequence
   initial begin
      rst_n         = 1'b0;
      avs_address   = 5'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      abort_arm     = 1'b0;
      errors        = 0;
      n_checks      = 0;
      ticks         = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_erase();
      t_refused();
      t_bad_addr();
      t_abort();
      close_out();
   end
endmodule
